// ===== common/ccs_pkg.sv
// ccs_pkg: constants, types and helpers of the cyclic control/status exchange
// assumes a 100 MHz system clock; shared by the exchange and its tare engine
package ccs_pkg;
  // timing
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned TARE_SPACING_US  = 1000;
  localparam int unsigned TARE_SPACING_CYC = TARE_SPACING_US * CLK_MHZ;
  localparam int unsigned TARE_READINGS    = 500;
  localparam int unsigned LED_HALF_MS      = 500;
  localparam int unsigned LED_HALF_CYC     = LED_HALF_MS * 1000 * CLK_MHZ;
  localparam int unsigned BLINK_W          = 27;
  localparam int unsigned SPACE_W          = 20;
  localparam int unsigned NREAD_W          = 10;
  // control byte 1 and 2 bit positions
  localparam int unsigned C1_FREEZE  = 0;
  localparam int unsigned C1_TARE    = 1;
  localparam int unsigned C1_CLRTARE = 2;
  localparam int unsigned C1_RMEAN   = 3;
  localparam int unsigned C1_REVAL   = 4;
  localparam int unsigned C1_RMIN    = 5;
  localparam int unsigned C1_RMAX    = 6;
  localparam int unsigned C2_TEST    = 0;
  localparam int unsigned C2_MODE_A  = 1;
  localparam int unsigned C2_MODE_B  = 2;
  localparam int unsigned C2_SAVE    = 3;
  localparam int unsigned C2_ADOPT   = 4;
  localparam int unsigned C2_SHUNT_A = 5;
  localparam logic [7:0]  HS1_MASK   = 8'h7E;
  localparam logic [7:0]  HS2_MASK   = 8'h19;
  // status byte 1 bit positions (eval bits sit at 3:0)
  localparam int unsigned S1_NOK_LOW  = 0;
  localparam int unsigned S1_NOK_HIGH = 2;
  localparam int unsigned S1_VALID    = 3;
  localparam int unsigned S1_TARE     = 6;
  // register map
  localparam logic [7:0]  REG_CFG   = 8'h00;
  localparam logic [7:0]  REG_STAT  = 8'h04;
  localparam logic [7:0]  REG_TARE  = 8'h08;
  localparam logic [7:0]  REG_MIN   = 8'h0C;
  localparam logic [7:0]  REG_MAX   = 8'h10;
  localparam logic [7:0]  REG_UPPER = 8'h14;
  localparam logic [7:0]  REG_LOWER = 8'h18;
  localparam int unsigned CFG_SWAP  = 8;
  localparam logic [15:0] CFG_RST   = 16'h0001;
  localparam logic [31:0] MIN_RST   = 32'h7FFFFFFF;
  localparam logic [31:0] MAX_RST   = 32'h80000000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [2:0]  SH_LAST   = 3'h4;

  typedef enum logic [1:0] {
    MM_DC             = 2'h0,
    MM_REVERSING_DC   = 2'h1,
    MM_ALTERNATING    = 2'h2,
    MM_INVALID        = 2'h3
  } ccs_mmode_t;

  // swap the four bytes of a transferred value when asked
  function automatic logic [31:0] ccs_order(input logic [31:0] v, input logic sw);
    ccs_order = sw ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
  endfunction
endpackage

// ===== common/ccs_tare_if.sv
// ccs_tare_if: request and result signals between the exchange and its tare engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface ccs_tare_if;
  logic        start;
  logic        clear;
  logic [31:0] raw;
  logic        busy;
  logic [31:0] tare;
  modport ctl (output start, output clear, output raw, input busy, input tare);
  modport eng (input start, input clear, input raw, output busy, output tare);
endinterface

// ===== hw/ccs_tare.sv
// ccs_tare: averages a fixed number of evenly spaced raw readings into a tare value
// assumes start and clear are one-cycle pulses and raw is always a fresh reading
`timescale 1ns/1ps
module ccs_tare #(
  parameter int unsigned SPACING_CYC = ccs_pkg::TARE_SPACING_CYC,
  parameter int unsigned READINGS    = ccs_pkg::TARE_READINGS
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  ccs_tare_if.eng   tif
);
  typedef struct packed {
    logic                        busy;
    logic [ccs_pkg::SPACE_W-1:0] space;
    logic [ccs_pkg::NREAD_W-1:0] nread;
    logic [41:0]                 sum;
    logic [31:0]                 tare;
  } ccs_tare_st_t;

  ccs_tare_st_t s_q;
  ccs_tare_st_t s_d;
  logic [41:0]  sum_n;
  logic [41:0]  avg;

  // acquisition sequencer; clear aborts a running acquisition
  always_comb begin
    s_d   = s_q;
    sum_n = s_q.sum + {{10{tif.raw[31]}}, tif.raw};
    avg   = 42'($signed(sum_n) / $signed(42'(READINGS)));
    if (tif.clear) begin
      s_d.busy = 1'b0;
      s_d.tare = 32'h0;
    end else if (!s_q.busy) begin
      if (tif.start) begin
        s_d.busy  = 1'b1;
        s_d.space = '0;
        s_d.nread = '0;
        s_d.sum   = '0;
      end
    end else if (s_q.space != ccs_pkg::SPACE_W'(SPACING_CYC - 1)) begin
      s_d.space = s_q.space + 1'b1;
    end else begin
      s_d.space = '0;
      s_d.sum   = sum_n;
      s_d.nread = s_q.nread + 1'b1;
      if (s_q.nread == ccs_pkg::NREAD_W'(READINGS - 1)) begin
        s_d.busy = 1'b0;
        s_d.tare = avg[31:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.busy = s_q.busy;
  assign tif.tare = s_q.tare;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tare_cleared: assert property (
    tif.clear |=> (s_q.tare == 32'h0) && !s_q.busy)
    else $error("tare not cleared after clear request");
endmodule

// ===== hw/ccs_exchange.sv
// ccs_exchange: interprets the two cyclic control bytes and builds the status reply
// assumes the fieldbus engine, front end and evaluator share aclk; axi4-lite slave
//
// Notes on behaviour
// - four-bit toggle count steps by one, wrapping, on every new measured value.
// - tare flag is high exactly while a nonzero tare value is subtracted.
// - action bits act on a rising edge only; progress shows in handshakes.
// - state bits are mirrored as the applied setting, without handshake.
// - freeze skips evaluation, holds result, clears valid, blinks red slowly.
// - tare edge averages 500 readings 1 ms apart, then subtracts and flags.
// - clear-tare edge discards tare value and drops the tare flag.
// - mean reset restarts averaging from scratch.
// - evaluation reset clears latched out-of-tolerance result and restarts.
// - min or max reset edge reloads that buffer with the current value.
// - sensor test edge starts a test, outcome reported in status flags.
// - mode bits B,A: 00 DC, 01 reversing, 10 alternating, 11 invalid.
// - a new measuring mode applies only when the running average completes.
// - save edge stores setup; nothing else saves mode, limits or shunt.
// - adopt edge takes the limits, only in modes that carry limits.
// - shunt C,B,A: open, short, 59k, 80k, 100k; other codes ignored.
// - mode known by code sequence: A1, A3 per limit, 93 per input word.
// - user parameter lsb reverses byte order of every transferred value.
// - mode 1 sends status, mirror, current value; receives two control bytes.
// - mirror bytes show the handshakes and the applied freeze, mode and shunt, not the control bits.
// - test start clears validity; outcome sets result and validity.
`timescale 1ns/1ps
module ccs_exchange #(
  parameter int unsigned TARE_SPACING_CYC = ccs_pkg::TARE_SPACING_CYC,
  parameter int unsigned TARE_READINGS    = ccs_pkg::TARE_READINGS,
  parameter int unsigned LED_HALF_CYC     = ccs_pkg::LED_HALF_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] control_output_bytes,
  input  wire logic [31:0] limit_upper_in,
  input  wire logic [31:0] limit_lower_in,
  output logic [31:0]      status_input_bytes,
  output logic [31:0]      value_word,
  output logic [31:0]      min_word,
  output logic [31:0]      max_word,
  output logic [7:0]       input_length,
  input  wire logic        meas_valid,
  input  wire logic [31:0] meas_value,
  input  wire logic        mean_done,
  input  wire logic [3:0]  eval_result,
  input  wire logic        test_done,
  input  wire logic        test_pass,
  output logic             mean_reset,
  output logic             eval_reset,
  output logic             eval_hold,
  output logic             test_start,
  output logic             setup_save,
  output logic             led_red,
  output logic [1:0]       meas_mode,
  output logic [2:0]       shunt_sel,
  output logic [31:0]      limit_upper,
  output logic [31:0]      limit_lower
);
  typedef struct packed {
    logic [7:0]                  c1;
    logic [7:0]                  c2;
    logic [7:0]                  m1;
    logic [7:0]                  m2;
    logic [3:0]                  ev;
    logic                        tres;
    logic                        tval;
    logic [3:0]                  tog;
    logic [31:0]                 cur;
    logic [31:0]                 min;
    logic [31:0]                 max;
    logic [31:0]                 up;
    logic [31:0]                 lo;
    ccs_pkg::ccs_mmode_t         mode;
    logic [2:0]                  shunt;
    logic                        frz;
    logic                        led;
    logic [ccs_pkg::BLINK_W-1:0] blink;
    logic                        mean_rst;
    logic                        eval_rst;
    logic                        test_go;
    logic                        save;
    logic                        tstart;
    logic                        tclr;
    logic [31:0]                 sib;
    logic [31:0]                 valw;
    logic [31:0]                 minw;
    logic [31:0]                 maxw;
    logic [7:0]                  inlen;
    logic [15:0]                 cfg;
    logic                        awr;
    logic                        wr;
    logic                        awh;
    logic                        wh;
    logic [7:0]                  awa;
    logic [15:0]                 wd;
    logic [1:0]                  ws;
    logic                        bv;
    logic [1:0]                  br;
    logic                        arr;
    logic                        rv;
    logic [31:0]                 rd;
    logic [1:0]                  rr;
  } ccs_st_t;

  ccs_st_t     s_q;
  ccs_st_t     s_d;
  logic [7:0]  c1;
  logic [7:0]  c2;
  logic [7:0]  rise1;
  logic [7:0]  rise2;
  logic [31:0] cur_n;
  logic        has_lim;
  logic        swap;

  ccs_tare_if tif ();

  ccs_tare #(
    .SPACING_CYC (TARE_SPACING_CYC),
    .READINGS    (TARE_READINGS)
  ) u_tare (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tif     (tif)
  );

  // limit codes and input codes of a mode number
  function automatic logic [3:0] ccs_limit_codes(input logic [3:0] mode);
    ccs_limit_codes = mode[0] ? 4'h0 : 4'h2;
  endfunction

  function automatic logic [3:0] ccs_input_codes(input logic [3:0] mode);
    ccs_input_codes = ((mode + 4'h1) >> 1) + 4'h1;
  endfunction

  // main next-state logic: control decode, mirrors, status, register bus
  always_comb begin
    s_d     = s_q;
    c1      = control_output_bytes[7:0];
    c2      = control_output_bytes[15:8];
    // actions fire on rising edges only
    rise1   = c1 & ~s_q.c1;
    rise2   = c2 & ~s_q.c2;
    swap    = s_q.cfg[ccs_pkg::CFG_SWAP];
    has_lim = ccs_limit_codes(s_q.cfg[3:0]) != 4'h0;
    cur_n   = meas_valid ? meas_value - tif.tare : s_q.cur;
    s_d.c1  = c1;
    s_d.c2  = c2;

    // one-cycle action requests to the tare engine, front end, evaluator and setup store
    s_d.tstart   = rise1[ccs_pkg::C1_TARE];
    s_d.tclr     = rise1[ccs_pkg::C1_CLRTARE];
    s_d.mean_rst = rise1[ccs_pkg::C1_RMEAN];
    s_d.eval_rst = rise1[ccs_pkg::C1_REVAL];
    s_d.test_go  = rise2[ccs_pkg::C2_TEST];
    // the only trigger of a setup save
    s_d.save     = rise2[ccs_pkg::C2_SAVE];

    // freeze holds the result and forces it invalid
    s_d.frz = c1[ccs_pkg::C1_FREEZE];
    if (s_d.frz) begin
      s_d.ev = {1'b0, s_q.ev[2:0]};
    end else begin
      s_d.ev = eval_result;
    end
    if (rise1[ccs_pkg::C1_REVAL]) begin
      s_d.ev[ccs_pkg::S1_NOK_LOW]  = 1'b0;
      s_d.ev[ccs_pkg::S1_NOK_HIGH] = 1'b0;
    end

    // slow red blink while frozen, dark otherwise
    if (!s_d.frz) begin
      s_d.blink = '0;
      s_d.led   = 1'b0;
    end else if (s_q.blink == ccs_pkg::BLINK_W'(LED_HALF_CYC - 1)) begin
      s_d.blink = '0;
      s_d.led   = !s_q.led;
    end else begin
      s_d.blink = s_q.blink + 1'b1;
    end

    // start clears validity; outcome placed after so it wins
    if (rise2[ccs_pkg::C2_TEST]) begin
      s_d.tval = 1'b0;
    end
    if (test_done) begin
      s_d.tres = test_pass;
      s_d.tval = 1'b1;
    end

    // requested mode waits for the end of the running average
    if (mean_done && (c2[2:1] != 2'(ccs_pkg::MM_INVALID))) begin
      s_d.mode = ccs_pkg::ccs_mmode_t'(c2[2:1]);
    end
    // unknown shunt codes leave the connection as it was
    if (c2[7:5] <= ccs_pkg::SH_LAST) begin
      s_d.shunt = c2[7:5];
    end

    // new measured value steps the toggle count
    if (meas_valid) begin
      s_d.tog = s_q.tog + 4'h1;
      s_d.cur = cur_n;
      if ($signed(cur_n) < $signed(s_q.min)) begin
        s_d.min = cur_n;
      end
      if ($signed(cur_n) > $signed(s_q.max)) begin
        s_d.max = cur_n;
      end
    end
    // reset reloads the buffer with the current value
    if (rise1[ccs_pkg::C1_RMIN]) begin
      s_d.min = cur_n;
    end
    if (rise1[ccs_pkg::C1_RMAX]) begin
      s_d.max = cur_n;
    end

    // limits follow the control bytes, order per user byte
    if (rise2[ccs_pkg::C2_ADOPT] && has_lim) begin
      s_d.up = ccs_pkg::ccs_order(limit_upper_in, swap);
      s_d.lo = ccs_pkg::ccs_order(limit_lower_in, swap);
    end

    // handshakes set on start, held until the bit drops
    s_d.m1 = ((rise1 | (s_q.m1 & c1)) & ccs_pkg::HS1_MASK) | {7'h0, s_d.frz};
    // state bits show what is applied, not what is asked
    s_d.m2 = ((rise2 | (s_q.m2 & c2)) & ccs_pkg::HS2_MASK)
           | {s_d.shunt, 2'h0, s_d.mode, 1'b0};

    // status words in input byte order
    s_d.sib   = {s_d.m2, s_d.m1, 4'h0, s_d.tog,
                 1'b0, tif.tare != 32'h0, s_d.tval, s_d.tres, s_d.ev};
    // byte order of every transferred value
    s_d.valw  = ccs_pkg::ccs_order(s_d.cur, swap);
    s_d.minw  = ccs_pkg::ccs_order(s_d.min, swap);
    s_d.maxw  = ccs_pkg::ccs_order(s_d.max, swap);
    s_d.inlen = {2'h0, ccs_input_codes(s_q.cfg[3:0]), 2'h0};

    // axi write: address and data taken in either order, answered once both held
    if (s_axi_awvalid && s_q.awr) begin
      s_d.awa = s_axi_awaddr;
      s_d.awh = 1'b1;
      s_d.awr = 1'b0;
    end
    if (s_axi_wvalid && s_q.wr) begin
      s_d.wd  = s_axi_wdata[15:0];
      s_d.ws  = s_axi_wstrb[1:0];
      s_d.wh  = 1'b1;
      s_d.wr  = 1'b0;
    end
    if (s_q.awh && s_q.wh && !s_q.bv) begin
      s_d.awh = 1'b0;
      s_d.wh  = 1'b0;
      s_d.bv  = 1'b1;
      s_d.br  = ccs_pkg::RESP_SLVERR;
      if (s_q.awa == ccs_pkg::REG_CFG) begin
        s_d.br = ccs_pkg::RESP_OKAY;
        if (s_q.ws[0]) begin
          s_d.cfg[7:0] = s_q.wd[7:0];
        end
        if (s_q.ws[1]) begin
          s_d.cfg[15:8] = s_q.wd[15:8];
        end
      end
    end
    if (s_q.bv && s_axi_bready) begin
      s_d.bv  = 1'b0;
      s_d.awr = 1'b1;
      s_d.wr  = 1'b1;
    end

    // axi read: one outstanding read, unmapped answers zero with slverr
    if (s_axi_arvalid && s_q.arr) begin
      s_d.arr = 1'b0;
      s_d.rv  = 1'b1;
      s_d.rr  = ccs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ccs_pkg::REG_CFG: begin
          s_d.rd = {16'h0, s_q.cfg};
        end
        ccs_pkg::REG_STAT: begin
          s_d.rd = s_q.sib;
        end
        ccs_pkg::REG_TARE: begin
          s_d.rd = tif.tare;
        end
        ccs_pkg::REG_MIN: begin
          s_d.rd = s_q.min;
        end
        ccs_pkg::REG_MAX: begin
          s_d.rd = s_q.max;
        end
        ccs_pkg::REG_UPPER: begin
          s_d.rd = s_q.up;
        end
        ccs_pkg::REG_LOWER: begin
          s_d.rd = s_q.lo;
        end
        default: begin
          s_d.rd = 32'h0;
          s_d.rr = ccs_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_q.rv && s_axi_rready) begin
      s_d.rv  = 1'b0;
      s_d.arr = 1'b1;
    end
  end

  // state register; extreme buffers start at the opposite ends of the range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q     <= '0;
      s_q.awr <= 1'b1;
      s_q.wr  <= 1'b1;
      s_q.arr <= 1'b1;
      s_q.cfg <= ccs_pkg::CFG_RST;
      s_q.min <= ccs_pkg::MIN_RST;
      s_q.max <= ccs_pkg::MAX_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // tare engine requests come from flops, raw reading straight through
  assign tif.start = s_q.tstart;
  assign tif.clear = s_q.tclr;
  assign tif.raw   = meas_value;

  // outputs, all from the state register
  assign s_axi_awready      = s_q.awr;
  assign s_axi_wready       = s_q.wr;
  assign s_axi_bvalid       = s_q.bv;
  assign s_axi_bresp        = s_q.br;
  assign s_axi_arready      = s_q.arr;
  assign s_axi_rvalid       = s_q.rv;
  assign s_axi_rdata        = s_q.rd;
  assign s_axi_rresp        = s_q.rr;
  assign status_input_bytes = s_q.sib;
  assign value_word         = s_q.valw;
  assign min_word           = s_q.minw;
  assign max_word           = s_q.maxw;
  assign input_length       = s_q.inlen;
  assign mean_reset         = s_q.mean_rst;
  assign eval_reset         = s_q.eval_rst;
  assign eval_hold          = s_q.frz;
  assign test_start         = s_q.test_go;
  assign setup_save         = s_q.save;
  assign led_red            = s_q.led;
  assign meas_mode          = s_q.mode;
  assign shunt_sel          = s_q.shunt;
  assign limit_upper        = s_q.up;
  assign limit_lower        = s_q.lo;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_tare_rise;
    $rose(control_output_bytes[ccs_pkg::C1_TARE]);
  endsequence
  sequence s_tare_drop;
    !control_output_bytes[ccs_pkg::C1_TARE] ##1 !control_output_bytes[ccs_pkg::C1_TARE];
  endsequence

  a_toggle_step: assert property (
    meas_valid |=> s_q.tog == 4'($past(s_q.tog) + 4'h1))
    else $error("toggle count did not step by one");
  a_tare_flag: assert property (
    s_q.sib[ccs_pkg::S1_TARE] == ($past(tif.tare) != 32'h0))
    else $error("tare flag disagrees with tare value");
  a_action_edge: assert property (
    s_q.test_go |-> $past(control_output_bytes[8]) && !$past(control_output_bytes[8], 2))
    else $error("sensor test started without a rising edge");
  a_hs_set: assert property (
    s_tare_rise |=> s_q.sib[17] ##1 (s_q.sib[17] || !$past(control_output_bytes[1])))
    else $error("tare handshake missing after start");
  a_hs_clear: assert property (
    s_tare_drop |=> !s_q.sib[17])
    else $error("tare handshake not cleared after drop");
  a_state_mirror: assert property (
    s_q.sib[31:29] == s_q.shunt && s_q.sib[26:25] == s_q.mode)
    else $error("mirror does not show applied state");
  a_freeze_valid: assert property (
    control_output_bytes[ccs_pkg::C1_FREEZE] |=> !s_q.sib[ccs_pkg::S1_VALID] && eval_hold)
    else $error("evaluation valid while frozen");
  a_mode_wait: assert property (
    $changed(s_q.mode) |-> $past(mean_done))
    else $error("measuring mode changed outside an average end");
  a_adopt_gate: assert property (
    $changed(s_q.up) |-> $past(has_lim) && $past(control_output_bytes[12])
      && !$past(control_output_bytes[12], 2))
    else $error("limits changed without adopt edge in a limit mode");
  a_shunt_legal: assert property (
    s_q.shunt <= ccs_pkg::SH_LAST)
    else $error("undefined shunt code applied");
  a_test_result: assert property (
    test_done |=> s_q.tval && s_q.tres == $past(test_pass))
    else $error("sensor test outcome not reported");
  a_word_order: assert property (
    s_q.valw == ccs_pkg::ccs_order(s_q.cur, $past(s_q.cfg[ccs_pkg::CFG_SWAP])))
    else $error("value word in wrong byte order");
endmodule

// ===== verif/ccs_master_model.sv
// ccs_master_model: fieldbus master that drives the two control bytes
// assumes handshakes come back in status bytes 3 and 4
`timescale 1ns/1ps
module ccs_master_model (
  input wire logic  aclk,
  input wire logic [31:0] status_input_bytes,
  output logic [15:0] control_output_bytes
);
  int n_to = 0;
  // bit positions; all idle at start
  initial control_output_bytes = 16'h0000;
  task automatic act(input int b);
    int k;
    @(posedge aclk);
    control_output_bytes[b] <= 1'b1;
    for (k = 0; k < 50 && status_input_bytes[16+b] !== 1'b1; k++) @(negedge aclk);
    if (k == 50) n_to++;
    @(posedge aclk);
    control_output_bytes[b] <= 1'b0;
  endtask
  task automatic set(input int b, input logic v);
    @(posedge aclk);
    control_output_bytes[b] <= v;
  endtask
endmodule

// ===== verif/ccs_exchange_tb.sv
// ccs_exchange_tb: self-checking bench for the control/status exchange
// assumes the master model on the control bytes; bench plays front end and bus
`timescale 1ns/1ps
module ccs_exchange_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, meas_valid, mean_done, test_done, test_pass, mean_reset;
  logic eval_reset, eval_hold, test_start, setup_save, led_red;
  logic [1:0] s_axi_bresp, s_axi_rresp, meas_mode, rsp;
  logic [2:0] shunt_sel;
  logic [3:0] s_axi_wstrb, eval_result;
  logic [7:0] s_axi_awaddr, s_axi_araddr, input_length;
  logic [15:0] control_output_bytes;
  logic [31:0] s_axi_wdata, s_axi_rdata, limit_upper_in, limit_lower_in, status_input_bytes;
  logic [31:0] value_word, min_word, max_word, meas_value, limit_upper, limit_lower, rd;
  int n_fail = 0, checked = 0, i, n_p = 0;
  // raw reading beside expected reported value
  logic [31:0] rows [3][2] = '{'{32'h5, 32'h5}, '{32'hFFFFFFFE, 32'hFFFFFFFE}, '{32'h100, 32'h100}};
  // short tare and blink counts keep the run brief
  ccs_exchange #(.TARE_SPACING_CYC(4), .TARE_READINGS(4), .LED_HALF_CYC(8)) ccs_exchange_inst (.*);
  ccs_master_model ccs_master_model_inst (.aclk, .status_input_bytes, .control_output_bytes);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // one count per action pulse; a stuck pulse inflates the total
  always @(posedge aclk) n_p += mean_reset + eval_reset + test_start + setup_save;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a wait that ran out ends the run
  task automatic to_chk(input int k);
    if (k >= 40) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic meas(input logic [31:0] v);
    @(posedge aclk);
    meas_value <= v;
    meas_valid <= 1'b1;
    @(posedge aclk);
    meas_valid <= 1'b0;
    tick(1);
  endtask
  // address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40 && s_axi_bvalid !== 1'b1; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    to_chk(k);
  endtask
  task automatic axr(input logic [7:0] a);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40 && s_axi_rvalid !== 1'b1; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    to_chk(k);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {meas_valid, mean_done, test_done, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {limit_upper_in, limit_lower_in, meas_value} = '0;
    {test_pass, s_axi_wstrb, eval_result, aresetn} = {1'b1, 4'h3, 4'hD, 1'b0};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    chk("min", min_word, ccs_pkg::MIN_RST);
    chk("max", max_word, ccs_pkg::MAX_RST);
    for (i = 0; i < 3; i++) begin
      meas(rows[i][0]);
      chk("value", value_word, rows[i][1]);
      chk("toggle", status_input_bytes[11:8], i + 1);
    end
    chk("min", min_word, 32'hFFFFFFFE);
    chk("max", max_word, 32'h00000100);
    // thirteen unpolled readings; the master sees the count jump round to zero
    for (i = 0; i < 13; i++) meas(32'h100);
    chk("toggle", status_input_bytes[11:8], 0);
    ccs_master_model_inst.act(5);
    tick(2);
    chk("min", min_word, 32'h00000100);
    chk("hs", status_input_bytes[21], 0);
    ccs_master_model_inst.act(1);
    for (i = 0; i < 60 && status_input_bytes[6] !== 1'b1; i++) tick(0);
    chk("tflag", status_input_bytes[6], 1);
    meas(32'h103);
    chk("tared", value_word, 32'h3);
    ccs_master_model_inst.act(2);
    tick(2);
    chk("tflag", status_input_bytes[6], 0);
    ccs_master_model_inst.act(3);
    ccs_master_model_inst.act(11);
    ccs_master_model_inst.set(9, 1'b1);
    tick(3);
    chk("mode", meas_mode, 0);
    @(posedge aclk);
    mean_done <= 1'b1;
    @(posedge aclk);
    mean_done <= 1'b0;
    tick(1);
    chk("mode", meas_mode, 1);
    chk("modemir", status_input_bytes[26:25], 1);
    ccs_master_model_inst.set(14, 1'b1);
    tick(2);
    chk("shunt", shunt_sel, 2);
    chk("shmir", status_input_bytes[31:29], 2);
    ccs_master_model_inst.set(0, 1'b1);
    tick(2);
    chk("hold", eval_hold, 1);
    chk("valid", status_input_bytes[3], 0);
    for (i = 0; i < 20 && led_red !== 1'b1; i++) tick(0);
    for (i = 0; i < 20 && led_red === 1'b1; i++) tick(0);
    chk("blink", i, 8);
    @(posedge aclk);
    eval_result <= 4'hA;
    tick(1);
    chk("held", status_input_bytes[3:0], 4'h5);
    ccs_master_model_inst.act(4);
    tick(1);
    chk("nok", status_input_bytes[3:0], 4'h0);
    for (i = 0; i < 2; i++) begin
      ccs_master_model_inst.act(8);
      chk("tvalid", status_input_bytes[5], 0);
      @(posedge aclk);
      test_done <= 1'b1;
      test_pass <= (i == 0);
      @(posedge aclk);
      test_done <= 1'b0;
      tick(1);
      chk("test", status_input_bytes[5:4], 3 - i);
    end
    axr(ccs_pkg::REG_CFG);
    chk("cfg", rd, 32'h1);
    axr(8'h40);
    chk("resp", rsp, ccs_pkg::RESP_SLVERR);
    for (i = 1; i < 9; i++) begin
      axw(ccs_pkg::REG_CFG, i);
      tick(1);
      chk("len", input_length, 4 * ((i + 3) / 2));
    end
    {limit_upper_in, limit_lower_in} <= {32'h0A0B0C0D, 32'h01020304}; // limits
    axw(ccs_pkg::REG_CFG, 32'h0101);
    ccs_master_model_inst.act(12);
    tick(1);
    chk("upper", limit_upper, 0);
    axw(ccs_pkg::REG_CFG, 32'h0102);
    chk("resp", rsp, ccs_pkg::RESP_OKAY);
    ccs_master_model_inst.act(12);
    tick(1);
    chk("upper", limit_upper, 32'h0D0C0B0A);
    chk("lower", limit_lower, 32'h04030201);
    s_axi_wstrb <= 4'h1;
    axw(ccs_pkg::REG_CFG, 32'h0003);
    axr(ccs_pkg::REG_CFG);
    chk("strb", rd, 32'h0103);
    meas(32'h11223344);
    chk("swap", value_word, 32'h44332211);
    chk("hsto", ccs_master_model_inst.n_to, 0);
    chk("pulses", n_p, 5);
    give_verdict();
  end
endmodule
